// ### hw/pea_top.v
// Pre-echo onset refinement, trend check, low-band smoothing and apply.
// Assumes upstream logic supplies envelopes, gains and frame sample stream.
`timescale 1ns/1ps
`include "pea_defs.vh"
module pea_top #(
  parameter DW  = 16,
  parameter EW  = 40,
  parameter GW  = 16,
  parameter LSF = 40
) (
  input  wire          CLK,
  input  wire          RESET_N,
  input  wire          FRAME_START,
  input  wire          NARROWBAND,
  input  wire          RATE_8K,
  input  wire [3:0]    PEAK_SUBBLOCK_INDEX,
  input  wire [3:0]    FIRST_NONECHO_SUBBLOCK_INDEX,
  input  wire [EW-1:0] PEAK_ENERGY,
  input  wire [EW-1:0] LAST_ECHO_ENERGY,
  input  wire [7:0]    NONECHO_ZCR,
  input  wire [EW-1:0] REF_ENERGY,
  input  wire [EW-1:0] NOISE_ENERGY_IN,
  input  wire [EW-1:0] FB_ENERGY_M1,
  input  wire [EW-1:0] FB_ENERGY_M3,
  input  wire [EW-1:0] HB_ENERGY_0,
  input  wire [EW-1:0] HB_ENERGY_1,
  input  wire [EW-1:0] HB_ENERGY_M1,
  input  wire [EW-1:0] HB_ENERGY_M2,
  input  wire [EW-1:0] HB_ENERGY_M3,
  input  wire [GW-1:0] LB_GAIN_IN,
  input  wire [GW-1:0] HIGH_BAND_GAIN,
  input  wire [GW-1:0] LAST_ECHO_LB_GAIN,
  input  wire [GW-1:0] LAST_ECHO_HB_GAIN,
  input  wire          SCAN_VALID,
  input  wire [DW-1:0] SCAN_SAMPLE,
  input  wire          SCAN_DONE,
  input  wire          SMP_VALID,
  input  wire [DW-1:0] LB_SAMPLE,
  input  wire [DW-1:0] HB_SAMPLE,
  input  wire          SMP_LAST,
  output wire [DW-1:0] OUT_SAMPLE,
  output wire          OUT_VALID,
  output wire          INHIBIT,
  output wire [15:0]   ONSET_POS,
  output wire [EW-1:0] MIN_CRITERION,
  output wire [EW-1:0] PRIOR_NOISE_ENERGY,
  output wire          READY
);
  // ****************************************************************
  // Frame control
  // ****************************************************************
  localparam ST_IDLE  = 2'd0;
  localparam ST_SCAN  = 2'd1;
  localparam ST_APPLY = 2'd2;
  reg  [1:0]    state_reg;
  reg  [15:0]   pos_reg;
  reg  [15:0]   onset_reg;
  reg           advancing_reg;
  reg  [3:0]    ssb_cnt_reg;
  reg  [7:0]    ssb_idx_reg;
  reg  [EW-1:0] peak_ssb_reg;
  reg  [EW+3:0] sum_ssb_reg;
  reg  [EW-1:0] noise_reg;
  reg  [GW-1:0] last_gain_reg;
  reg           inhibit_reg;
  reg  [EW-1:0] mcrit_reg;
  reg           lookahead_reg;
  wire          rst_sync_n = RESET_N;
  wire [3:0]    nssf = RATE_8K ? `PEA_NSSF_8K : `PEA_NSSF_WIDE;
  wire [31:0]   lssf_full = LSF / nssf;
  wire [15:0]   lssf = lssf_full[15:0];
  wire [7:0]    zcr_lim = NARROWBAND ? `PEA_ZCR_NB : `PEA_ZCR_WIDE;
  wire [7:0]    slen = NARROWBAND ? `PEA_SMOOTH_NB : `PEA_SMOOTH_WIDE;
  wire          one_sub = lookahead_reg ||
                          (FIRST_NONECHO_SUBBLOCK_INDEX == 4'h0);
  wire [7:0]    ssb_total = one_sub ? {4'h0, nssf} :
                  (`PEA_NSF - FIRST_NONECHO_SUBBLOCK_INDEX) * nssf;
  // ****************************************************************
  // Sub-sub-block energy and thresholds
  // ****************************************************************
  wire [EW-1:0] ssb_e;
  wire          ssb_first = (ssb_cnt_reg == 4'h0);
  pea_ssb_energy #(.DW(DW), .EW(EW)) u_energy (
    .clk        (CLK),
    .reset_n    (rst_sync_n),
    .clr        (SCAN_VALID && ssb_first && state_reg == ST_SCAN),
    .acc        (SCAN_VALID && state_reg == ST_SCAN),
    .smp        (SCAN_SAMPLE),
    .energy_reg (ssb_e)
  );
  reg           ssb_done_reg;
  wire [EW-1:0] thr1 = peak_ssb_reg >> `PEA_THR1_SHIFT;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ssb_cnt_reg  <= 4'h0;
      ssb_done_reg <= 1'b0;
    end else begin
      ssb_done_reg <= 1'b0;
      if (state_reg != ST_SCAN) begin
        ssb_cnt_reg <= 4'h0;
      end else if (SCAN_VALID) begin
        if ({12'h0, ssb_cnt_reg} == lssf - 16'h1) begin
          ssb_cnt_reg  <= 4'h0;
          ssb_done_reg <= 1'b1;
        end else begin
          ssb_cnt_reg <= ssb_cnt_reg + 4'h1;
        end
      end
    end
  end
  // ****************************************************************
  // Frame sequencing, onset refinement and trend check
  // ****************************************************************
  wire [EW-1:0] mc_base = LAST_ECHO_ENERGY;
  wire [EW+15:0] mc_prod = mc_base * LAST_ECHO_LB_GAIN;
  wire [EW-1:0] mc_raw = mc_prod[EW+13:14];
  wire [EW-1:0] pk80 = PEAK_ENERGY / `PEA_MCRIT_DIV;
  wire [EW+1:0] hb_sum = HB_ENERGY_M1 + HB_ENERGY_M2 + HB_ENERGY_M3;
  wire [EW+4:0] hb_lhs = (HB_ENERGY_M1 - HB_ENERGY_M3) * `PEA_HB_NUM;
  wire [EW+4:0] hb_rhs = hb_sum * `PEA_HB_DEN;
  wire          hb_fall3 = (HB_ENERGY_M1 < HB_ENERGY_M3) ||
                           (hb_lhs < hb_rhs);
  wire          fb_fall3 = FB_ENERGY_M1 < FB_ENERGY_M3;
  wire          hb_fall2 = HB_ENERGY_1 < HB_ENERGY_0;
  reg           inh_next;
  always @* begin
    inh_next = 1'b0;
    if (PEAK_SUBBLOCK_INDEX < 4'h2) begin
      inh_next = 1'b0;
    end else if (PEAK_SUBBLOCK_INDEX == 4'h2) begin
      inh_next = hb_fall2;
    end else begin
      inh_next = fb_fall3 || hb_fall3;
    end
  end
  wire [31:0] onset_full = PEAK_SUBBLOCK_INDEX * LSF;
  wire [15:0] onset_base = onset_full[15:0];
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg     <= ST_IDLE;
      onset_reg     <= 16'h0;
      advancing_reg <= 1'b0;
      ssb_idx_reg   <= 8'h0;
      peak_ssb_reg  <= {EW{1'b0}};
      sum_ssb_reg   <= {(EW+4){1'b0}};
      inhibit_reg   <= 1'b0;
      mcrit_reg     <= {EW{1'b0}};
      lookahead_reg <= 1'b0;
      noise_reg     <= {EW{1'b0}};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (FRAME_START) begin
            state_reg     <= ST_SCAN;
            onset_reg     <= onset_base;
            advancing_reg <= 1'b1;
            ssb_idx_reg   <= 8'h0;
            peak_ssb_reg  <= {EW{1'b0}};
            sum_ssb_reg   <= {(EW+4){1'b0}};
            lookahead_reg <= (PEAK_SUBBLOCK_INDEX == `PEA_NSF);
            inhibit_reg   <= inh_next;
            if (pk80 > mc_raw && NONECHO_ZCR > zcr_lim) begin
              mcrit_reg <= pk80;
            end else begin
              mcrit_reg <= mc_raw;
            end
          end
        end
        ST_SCAN: begin
          if (ssb_done_reg && ssb_idx_reg < ssb_total) begin
            ssb_idx_reg <= ssb_idx_reg + 8'h1;
            sum_ssb_reg <= sum_ssb_reg + {4'h0, ssb_e};
            if (ssb_e > peak_ssb_reg) begin
              peak_ssb_reg <= ssb_e;
            end
          end
          if (SCAN_DONE) begin
            state_reg <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          if (SMP_VALID && SMP_LAST) begin
            state_reg <= ST_IDLE;
            noise_reg <= NOISE_ENERGY_IN;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // Energies stored during the scan are replayed in apply for the onset advance
  reg [EW-1:0] ssb_mem [0:63];
  reg [7:0]    chk_idx_reg;
  always @(posedge CLK) begin
    if (state_reg == ST_SCAN && ssb_done_reg) begin
      ssb_mem[ssb_idx_reg[5:0]] <= ssb_e;
    end
  end
  reg [EW+3:0] chk_sum_reg;
  wire [EW+3:0] c2num = {4'h0, REF_ENERGY} + (chk_sum_reg << 2);
  wire [EW+3:0] c2div = c2num / ({36'h0, chk_idx_reg} + 44'h1);
  wire [EW-1:0] c2raw = (|c2div[EW+3:EW]) ? {EW{1'b1}} : c2div[EW-1:0];
  wire [EW-1:0] c2 = (c2raw > noise_reg) ? c2raw : noise_reg;
  wire [EW-1:0] cmin = (thr1 < c2) ? thr1 : c2;
  wire [EW-1:0] chk_e = ssb_mem[chk_idx_reg[5:0]];
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      chk_idx_reg <= 8'h0;
      chk_sum_reg <= {(EW+4){1'b0}};
    end else if (state_reg != ST_APPLY) begin
      chk_idx_reg <= 8'h0;
      chk_sum_reg <= {(EW+4){1'b0}};
    end else if (advancing_reg && chk_idx_reg < ssb_idx_reg) begin
      if (chk_e < cmin) begin
        chk_idx_reg <= chk_idx_reg + 8'h1;
        chk_sum_reg <= chk_sum_reg + {4'h0, chk_e};
      end
    end
  end
  wire advance_ok = advancing_reg && chk_idx_reg < ssb_idx_reg &&
                    chk_e < cmin && state_reg == ST_APPLY;
  reg [15:0] adv_reg;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      adv_reg <= 16'h0;
    end else if (state_reg != ST_APPLY) begin
      adv_reg <= 16'h0;
    end else if (advance_ok) begin
      adv_reg <= adv_reg + lssf;
    end
  end
  wire [15:0] onset_now = onset_reg + adv_reg;
  wire        refine_busy = advancing_reg && chk_idx_reg < ssb_idx_reg &&
                            chk_e < cmin;
  // ****************************************************************
  // Gain selection and low-band smoothing
  // ****************************************************************
  wire        take = SMP_VALID && state_reg == ST_APPLY && !refine_busy;
  wire        in_moved = pos_reg >= onset_reg && pos_reg < onset_now;
  wire        in_echo = pos_reg < onset_now && !inhibit_reg;
  wire [GW-1:0] lb_tgt = inhibit_reg ? `PEA_GAIN_ONE :
                         in_moved ? LAST_ECHO_LB_GAIN : LB_GAIN_IN;
  wire [GW-1:0] hb_g   = inhibit_reg ? `PEA_GAIN_ONE :
                         in_moved ? LAST_ECHO_HB_GAIN :
                         HIGH_BAND_GAIN;
  reg  [GW-1:0] old_g_reg;
  reg  [GW-1:0] cur_g_reg;
  reg  [7:0]    ramp_reg;
  wire          at_bound = (pos_reg % LSF == 16'h0) ||
                           (pos_reg == onset_now);
  wire          start_ramp = at_bound && lb_tgt != cur_g_reg;
  wire [7:0]    step = start_ramp ? 8'h1 : ramp_reg;
  wire [GW-1:0] from_g = start_ramp ? cur_g_reg : old_g_reg;
  wire [GW+8:0] wsum = from_g * ({1'b0, slen} + 9'h1 - {1'b0, step}) +
                       lb_tgt * {1'b0, step};
  wire [GW+8:0] wdiv = wsum / ({1'b0, slen} + 9'h1);
  wire          ramping = start_ramp || (ramp_reg != 8'h0);
  wire [GW-1:0] lb_g = ramping ? wdiv[GW-1:0] : lb_tgt;
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pos_reg       <= 16'h0;
      old_g_reg     <= `PEA_GAIN_ONE;
      cur_g_reg     <= `PEA_GAIN_ONE;
      ramp_reg      <= 8'h0;
      last_gain_reg <= `PEA_GAIN_ONE;
    end else if (state_reg == ST_IDLE && FRAME_START) begin
      pos_reg   <= 16'h0;
      cur_g_reg <= last_gain_reg;
      ramp_reg  <= 8'h0;
    end else if (take) begin
      pos_reg <= pos_reg + 16'h1;
      if (start_ramp) begin
        old_g_reg <= cur_g_reg;
        cur_g_reg <= lb_tgt;
      end
      if (ramping && step < slen) begin
        ramp_reg <= step + 8'h1;
      end else begin
        ramp_reg <= 8'h0;
      end
      if (SMP_LAST) begin
        // Lookahead onset carries the transition into the next frame
        last_gain_reg <= lookahead_reg ? cur_g_reg : lb_tgt;
      end
    end
  end
  // ****************************************************************
  // Output
  // ****************************************************************
  pea_gain_apply #(.DW(DW), .GW(GW)) u_apply (
    .clk           (CLK),
    .reset_n       (rst_sync_n),
    .in_valid      (take),
    .lb            (LB_SAMPLE),
    .hb            (HB_SAMPLE),
    .g_lb          (in_echo || ramping ? lb_g : `PEA_GAIN_ONE),
    .g_hb          (in_echo ? hb_g : `PEA_GAIN_ONE),
    .out_reg       (OUT_SAMPLE),
    .out_valid_reg (OUT_VALID)
  );
  assign INHIBIT            = inhibit_reg;
  assign ONSET_POS          = onset_now;
  assign MIN_CRITERION      = mcrit_reg;
  assign PRIOR_NOISE_ENERGY = noise_reg;
  assign READY              = (state_reg == ST_APPLY) && !refine_busy;
endmodule

// ### hw/pea_defs.vh
// Constants for the pre-echo onset refinement and attenuation block.
// Assumes inclusion by name from the design files.
`ifndef PEA_DEFS_VH
`define PEA_DEFS_VH
`define PEA_NSF          4'h8
`define PEA_NSSF_8K      4'h4
`define PEA_NSSF_WIDE    4'h8
`define PEA_THR1_SHIFT   3
`define PEA_SUM_MULT     4
`define PEA_MCRIT_DIV    8'h50
`define PEA_ZCR_NB       8'h0A
`define PEA_ZCR_WIDE     8'h10
`define PEA_SMOOTH_NB    8'h14
`define PEA_SMOOTH_WIDE  8'h04
`define PEA_HB_NUM       4'hF
`define PEA_HB_DEN       2'h2
`define PEA_GAIN_ONE     16'h4000
`define PEA_GAIN_FRAC    14
`endif

// ### hw/pea_ssb_energy.v
// Sub-sub-block energy accumulator: sums squared samples over a length.
// Assumes the caller raises clr with the first sample of each length.
`timescale 1ns/1ps
module pea_ssb_energy #(
  parameter DW = 16,
  parameter EW = 40
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire          clr,
  input  wire          acc,
  input  wire [DW-1:0] smp,
  output reg  [EW-1:0] energy_reg
);
  wire signed [DW-1:0]   s_in = smp;
  wire signed [2*DW-1:0] sq   = s_in * s_in;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      energy_reg <= {EW{1'b0}};
    end else if (clr) begin
      energy_reg <= acc ? {{(EW-2*DW){1'b0}}, sq} : {EW{1'b0}};
    end else if (acc) begin
      energy_reg <= energy_reg + {{(EW-2*DW){1'b0}}, sq};
    end
  end
endmodule

// ### hw/pea_gain_apply.v
// Two-band gain multiply and sum, registered output.
// Assumes gains in Q2.14 and samples in two's complement.
`timescale 1ns/1ps
`include "pea_defs.vh"
module pea_gain_apply #(
  parameter DW = 16,
  parameter GW = 16
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire          in_valid,
  input  wire [DW-1:0] lb,
  input  wire [DW-1:0] hb,
  input  wire [GW-1:0] g_lb,
  input  wire [GW-1:0] g_hb,
  output reg  [DW-1:0] out_reg,
  output reg           out_valid_reg
);
  wire signed [DW-1:0]    lb_s = lb;
  wire signed [DW-1:0]    hb_s = hb;
  wire signed [GW:0]      glb  = {1'b0, g_lb};
  wire signed [GW:0]      ghb  = {1'b0, g_hb};
  wire signed [DW+GW:0]   p_lb = lb_s * glb;
  wire signed [DW+GW:0]   p_hb = hb_s * ghb;
  wire signed [DW+GW+1:0] sum  = p_lb + p_hb;
  wire signed [DW+GW+1:0] shf  = sum >>> `PEA_GAIN_FRAC;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_reg       <= {DW{1'b0}};
      out_valid_reg <= 1'b0;
    end else begin
      out_reg       <= shf[DW-1:0];
      out_valid_reg <= in_valid;
    end
  end
endmodule

// ### verif/pea_top_assertions.sv
// Checker for output timing, gain use and frame status of pea_top.
// Assumes one clock domain and binding onto every pea_top instance.
`timescale 1ns/1ps
`include "pea_defs.vh"
module pea_top_assertions #(
  parameter DW = 16,
  parameter EW = 40,
  parameter GW = 16
) (
  input wire          CLK,
  input wire          RESET_N,
  input wire          FRAME_START,
  input wire          SCAN_VALID,
  input wire          SMP_VALID,
  input wire          READY,
  input wire [DW-1:0] LB_SAMPLE,
  input wire [DW-1:0] HB_SAMPLE,
  input wire [GW-1:0] HIGH_BAND_GAIN,
  input wire [GW-1:0] LAST_ECHO_HB_GAIN,
  input wire [DW-1:0] OUT_SAMPLE,
  input wire          OUT_VALID,
  input wire          INHIBIT,
  input wire [15:0]   ONSET_POS,
  input wire [EW-1:0] MIN_CRITERION,
  input wire [EW-1:0] PRIOR_NOISE_ENERGY
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_take;
    SMP_VALID && READY;
  endsequence
  sequence s_apply2;
    READY ##1 READY;
  endsequence
  a_take_gives_out: assert property (s_take |=> OUT_VALID)
    else $error("no output after a taken sample");
  a_no_take_quiet: assert property (!(SMP_VALID && READY) |=> !OUT_VALID)
    else $error("output without a taken sample");
  a_hb_gain_direct: assert property (s_take ##0 (LB_SAMPLE == 0
    && HIGH_BAND_GAIN == `PEA_GAIN_ONE && LAST_ECHO_HB_GAIN == `PEA_GAIN_ONE)
    |=> OUT_SAMPLE == $past(HB_SAMPLE))
    else $error("high band not passed at unity gain");
  a_zero_in_out: assert property (s_take ##0 (LB_SAMPLE == 0
    && HB_SAMPLE == 0) |=> OUT_SAMPLE == 0)
    else $error("zero inputs gave nonzero output");
  a_scan_not_ready: assert property (SCAN_VALID |-> !READY)
    else $error("stream ready during scan");
  a_start_blocks_ready: assert property (FRAME_START |=> !READY [*2])
    else $error("ready right after frame start");
  a_status_stable: assert property (s_apply2 |->
    $stable(INHIBIT) && $stable(ONSET_POS))
    else $error("status moved during apply phase");
  a_mcrit_stable: assert property ($rose(READY) |=>
    $stable(MIN_CRITERION) [*3])
    else $error("minimum criterion moved during apply");
  a_noise_stable: assert property (OUT_VALID && READY |->
    $stable(PRIOR_NOISE_ENERGY))
    else $error("noise energy moved during apply");
endmodule
bind pea_top pea_top_assertions #(.DW(DW), .EW(EW), .GW(GW)) u_chk (
  .CLK(CLK), .RESET_N(RESET_N), .FRAME_START(FRAME_START),
  .SCAN_VALID(SCAN_VALID), .SMP_VALID(SMP_VALID), .READY(READY),
  .LB_SAMPLE(LB_SAMPLE), .HB_SAMPLE(HB_SAMPLE),
  .HIGH_BAND_GAIN(HIGH_BAND_GAIN), .LAST_ECHO_HB_GAIN(LAST_ECHO_HB_GAIN),
  .OUT_SAMPLE(OUT_SAMPLE), .OUT_VALID(OUT_VALID), .INHIBIT(INHIBIT),
  .ONSET_POS(ONSET_POS), .MIN_CRITERION(MIN_CRITERION),
  .PRIOR_NOISE_ENERGY(PRIOR_NOISE_ENERGY));

// ### verif/pea_src.sv
// Upstream model feeding the frame sample stream, with optional stalls.
// Assumes a go pulse after the scan and the block's ready level.
`timescale 1ns/1ps
module pea_src #(
  parameter DW = 16,
  parameter N  = 320
) (
  input  wire          clk,
  input  wire          go,
  input  wire          slow,
  input  wire [DW-1:0] lb_val,
  input  wire [DW-1:0] hb_val,
  input  wire          ready,
  output reg           valid,
  output reg  [DW-1:0] lb,
  output reg  [DW-1:0] hb,
  output reg           last,
  output reg           busy
);
  // ****************************************
  // Stream driver
  // ****************************************
  integer cnt = 0;
  reg     ph  = 0;
  reg     tk;
  reg     st;
  initial begin
    valid = 0; lb = 0; hb = 0; last = 0; busy = 0;
  end
  // Sample is held until taken; idle lines show a changing pattern
  always @(posedge clk) begin
    tk = valid && ready;
    st = go;
    #1;
    ph = ~ph;
    if (st && !busy) begin
      busy = 1; cnt = 0;
    end
    if (tk) cnt = cnt + 1;
    if (tk && last) busy = 0;
    if (busy && valid && !tk) begin
    end else if (busy && (!slow || ph)) begin
      valid = 1; lb = lb_val; hb = hb_val; last = (cnt == N - 1);
    end else begin
      valid = 0; lb = ~lb; hb = ~hb; last = 0;
    end
  end
endmodule

// ### verif/tb.sv
// Self-checking bench for pea_top: refinement, trend, criterion, smoothing.
// Assumes pea_src upstream model and the bound checker.
`timescale 1ns/1ps
`include "pea_defs.vh"
module tb;
  localparam LSF = 40;
  localparam L   = `PEA_NSF * LSF;
  reg         CLK = 0, RESET_N = 0, FRAME_START = 0, NARROWBAND = 0;
  reg         RATE_8K = 0, SCAN_VALID = 0, SCAN_DONE = 0, go = 0, slow = 0;
  reg         mon = 0;
  reg  [3:0]  idx = 0;
  reg  [7:0]  zcr = 0;
  reg  [15:0] scan_s = 0;
  reg  [39:0] e_pk = 0, e_le = 0, e_ref = 1000000;
  reg  [39:0] f1 = 0, f3 = 0, h0 = 0, h1 = 0, m1 = 0, m2 = 0, m3 = 0;
  integer     fails = 0, n_compared = 0, od = 0, dv, lbv = 0, hbv = 0;
  integer     g_lb = `PEA_GAIN_ONE, g_hb = `PEA_GAIN_ONE;
  integer     g_old = `PEA_GAIN_ONE, g_new = `PEA_GAIN_ONE;
  integer     g_mv = `PEA_GAIN_ONE, gh, eb = 0, eo = 0;
  wire [15:0] lbs, hbs, o_s, onset;
  wire [39:0] mc, pn;
  wire        sv, sl, busy, o_v, inh, rdy;
  always #20 CLK = ~CLK;
  pea_top #(.LSF(LSF)) dut_u (
    .CLK(CLK), .RESET_N(RESET_N), .FRAME_START(FRAME_START),
    .NARROWBAND(NARROWBAND), .RATE_8K(RATE_8K),
    .PEAK_SUBBLOCK_INDEX(idx), .FIRST_NONECHO_SUBBLOCK_INDEX(idx),
    .PEAK_ENERGY(e_pk), .LAST_ECHO_ENERGY(e_le), .NONECHO_ZCR(zcr),
    .REF_ENERGY(e_ref), .NOISE_ENERGY_IN(e_ref), .FB_ENERGY_M1(f1),
    .FB_ENERGY_M3(f3), .HB_ENERGY_0(h0), .HB_ENERGY_1(h1),
    .HB_ENERGY_M1(m1), .HB_ENERGY_M2(m2), .HB_ENERGY_M3(m3),
    .LB_GAIN_IN(g_lb[15:0]), .HIGH_BAND_GAIN(g_hb[15:0]),
    .LAST_ECHO_LB_GAIN(g_lb[15:0]), .LAST_ECHO_HB_GAIN(g_mv[15:0]),
    .SCAN_VALID(SCAN_VALID), .SCAN_SAMPLE(scan_s), .SCAN_DONE(SCAN_DONE),
    .SMP_VALID(sv), .LB_SAMPLE(lbs), .HB_SAMPLE(hbs), .SMP_LAST(sl),
    .OUT_SAMPLE(o_s), .OUT_VALID(o_v), .INHIBIT(inh), .ONSET_POS(onset),
    .MIN_CRITERION(mc), .PRIOR_NOISE_ENERGY(pn), .READY(rdy));
  pea_src #(.N(L)) src_u (
    .clk(CLK), .go(go), .slow(slow), .lb_val(lbv[15:0]),
    .hb_val(hbv[15:0]), .ready(rdy), .valid(sv), .lb(lbs), .hb(hbs),
    .last(sl), .busy(busy));
  // ****************************************
  // Helpers
  // ****************************************
  task tick;
    begin @(posedge CLK); #1; end
  endtask
  task complete_run;
    begin
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input logic ok, input string m);
    begin
      n_compared = n_compared + 1;
      if (ok !== 1'b1) begin
        fails = fails + 1;
        $display("[FAIL] %0t %0s", $time, m);
      end
    end
  endtask
  task tmo;
    begin
      fails = fails + 1;
      $display("[FAIL] %0t wait ran out", $time);
      complete_run;
    end
  endtask
  // Expected output: low band gain ramps from g_old to g_new
  // Echo zone uses the band gains, moved samples the last echo gain
  always @(posedge CLK) if (mon && o_v === 1'b1) begin
    gh = (od < eb) ? g_hb : (od < eo) ? g_mv : `PEA_GAIN_ONE;
    dv = NARROWBAND ? `PEA_SMOOTH_NB : `PEA_SMOOTH_WIDE;
    dv = (od < dv) ? g_old + (g_new - g_old) * (od + 1) / (dv + 1) : g_new;
    dv = (lbv * dv >>> `PEA_GAIN_FRAC) + (hbv * gh >>> `PEA_GAIN_FRAC)
         - $signed(o_s);
    chk(dv >= -2 && dv <= 2, "output sample");
    od = od + 1;
  end
  task frame(input [3:0] id, input integer ns, v0, v1, vb, adv);
    integer i;
    begin
      eb = id * LSF; eo = eb + adv;
      idx = id; od = 0; mon = 1; FRAME_START = 1;
      tick;
      FRAME_START = 0;
      for (i = 0; i < LSF; i = i + 1) begin
        SCAN_VALID = 1;
        scan_s = (i < ns) ? ((i < 5) ? v0 : v1) : vb;
        tick;
      end
      SCAN_VALID = 0; scan_s = ~scan_s; SCAN_DONE = 1;
      tick;
      SCAN_DONE = 0; scan_s = ~scan_s; i = 0;
      while (rdy !== 1'b1 && i < 300) begin tick; i = i + 1; end
      if (i == 300) tmo;
      chk(onset === eo, "onset position");
      go = 1;
      tick;
      go = 0;
      tick;
      i = 0;
      while (busy === 1'b1 && i < 3000) begin tick; i = i + 1; end
      if (i == 3000) tmo;
      tick;
      tick;
      chk(od === L, "output count");
      chk(pn === e_ref, "noise energy");
      mon = 0;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_refine;
    begin
      lbv = 100; hbv = 200; g_hb = `PEA_GAIN_ONE / 2; g_mv = g_hb / 2;
      frame(3, 5, 1, 1, 1000, 5);
      frame(5, 5, 400, 400, 1000, 0);
      frame(6, 10, 300, 490, 2000, 10);
      frame(8, 5, 1, 1, 1000, 5);
      RATE_8K = 1;
      frame(4, 10, 1, 1, 1000, 10);
      RATE_8K = 0; g_mv = `PEA_GAIN_ONE;
      $display("test refine done");
    end
  endtask
  task tr(input [3:0] id, input [39:0] a, b, c, d, e, f, g, input x);
    begin
      h0 = a; h1 = b; f1 = c; f3 = d; m1 = e; m2 = f; m3 = g;
      frame(id, 0, 0, 0, 1000, 0);
      chk(inh === x, "inhibit state");
    end
  endtask
  task t_trend;
    begin
      slow = 1; g_hb = `PEA_GAIN_ONE;
      tr(1, 50, 10, 0, 0, 0, 0, 0, 0);
      tr(2, 50, 10, 0, 0, 0, 0, 0, 1);
      tr(2, 10, 50, 0, 0, 0, 0, 0, 0);
      tr(4, 0, 0, 10, 50, 0, 0, 0, 1);
      tr(4, 0, 0, 50, 10, 40, 30, 30, 1);
      tr(4, 0, 0, 50, 10, 45, 30, 25, 0);
      slow = 0; f1 = 0; f3 = 0; m1 = 0; m2 = 0; m3 = 0;
      $display("test trend done");
    end
  endtask
  task mcr(input nb, input [7:0] z, input [39:0] x);
    begin
      NARROWBAND = nb; zcr = z; hbv = 300 * nb;
      frame(3, 0, 0, 0, 1000, 0);
      chk(mc === x, "minimum criterion");
    end
  endtask
  task t_mcrit;
    begin
      lbv = 0; e_pk = 8000; e_le = 50;
      mcr(0, 17, 100);
      mcr(0, 16, 50);
      mcr(1, 11, 100);
      mcr(1, 10, 50);
      NARROWBAND = 0;
      $display("test criterion done");
    end
  endtask
  task t_smooth;
    begin
      lbv = 1000; hbv = 0; g_hb = 0; g_lb = 0; g_new = 0;
      frame(8, 0, 0, 0, 1000, 0);
      g_old = 0; g_lb = `PEA_GAIN_ONE; g_new = g_lb; NARROWBAND = 1;
      frame(0, 0, 0, 0, 1000, 0);
      $display("test smoothing done");
    end
  endtask
  initial begin
    repeat (10) tick;
    RESET_N = 1;
    t_refine;
    t_trend;
    t_mcrit;
    t_smooth;
    complete_run;
  end
endmodule
